// file: core/dct_pkg.sv
// constants and carrier types for the dram command timing controller
`default_nettype none
package dct_pkg;
  localparam int unsigned CLK_PERIOD_PS = 20000;
  // times in picoseconds as printed (ns/us scaled)
  localparam int unsigned MODE_LOAD_SPACING_CK = 2;
  localparam int unsigned COLUMN_CMD_SPACING_CK = 2;
  localparam int unsigned ACTIVATE_SPACING_1K_PS = 7500;
  localparam int unsigned ACTIVATE_SPACING_2K_PS = 10000;
  localparam int unsigned FOUR_ACTIVATE_WINDOW_1K_PS = 37500;
  localparam int unsigned FOUR_ACTIVATE_WINDOW_2K_PS = 50000;
  localparam int unsigned WRITE_RECOVERY_PS = 15000;
  localparam int unsigned PRECHARGE_PERIOD_PS = 15000;
  localparam int unsigned WRITE_TO_READ_DELAY_PS = 10000;
  localparam int unsigned READ_TO_PRECHARGE_DELAY_PS = 7500;
  localparam int unsigned REFRESH_CYCLE_TIME_PS = 105000;
  localparam int unsigned SELFREFRESH_EXIT_EXTRA_PS = 10000;
  localparam int unsigned SELFREFRESH_EXIT_READ_CK = 200;
  localparam int unsigned PRECHARGE_PD_EXIT_CK = 2;
  localparam int unsigned ACTIVE_PD_EXIT_FAST_CK = 2;
  localparam int unsigned ACTIVE_PD_EXIT_SLOW_BASE_CK = 6;
  localparam int unsigned CLOCK_ENABLE_MIN_PULSE_CK = 3;
  localparam int unsigned TERMINATION_PD_ENTRY_CK = 3;
  localparam int unsigned TERMINATION_PD_EXIT_CK = 8;
  localparam int unsigned REFRESH_INTERVAL_NORMAL_PS = 7800000;
  localparam int unsigned REFRESH_INTERVAL_HOT_PS = 3900000;
  localparam int unsigned CLOCK_HOLD_AFTER_CKE_LOW_CK = 1;

  // least times round up
  function automatic int unsigned ps_to_ck(input int unsigned ps);
    return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction

  localparam int unsigned ACT_SPACING_1K_CK = ps_to_ck(ACTIVATE_SPACING_1K_PS);
  localparam int unsigned ACT_SPACING_2K_CK = ps_to_ck(ACTIVATE_SPACING_2K_PS);
  localparam int unsigned FAW_1K_CK = ps_to_ck(FOUR_ACTIVATE_WINDOW_1K_PS);
  localparam int unsigned FAW_2K_CK = ps_to_ck(FOUR_ACTIVATE_WINDOW_2K_PS);
  localparam int unsigned WRITE_RECOVERY_CK = ps_to_ck(WRITE_RECOVERY_PS);
  localparam int unsigned PRECHARGE_CK = ps_to_ck(PRECHARGE_PERIOD_PS);
  localparam int unsigned WTR_CK = ps_to_ck(WRITE_TO_READ_DELAY_PS);
  localparam int unsigned RTP_CK = ps_to_ck(READ_TO_PRECHARGE_DELAY_PS);
  localparam int unsigned SR_EXIT_NONREAD_CK =
    ps_to_ck(REFRESH_CYCLE_TIME_PS + SELFREFRESH_EXIT_EXTRA_PS);
  // average interval: round down
  localparam int unsigned REFRESH_NORMAL_CK =
    REFRESH_INTERVAL_NORMAL_PS / CLK_PERIOD_PS;
  localparam int unsigned REFRESH_HOT_CK = REFRESH_INTERVAL_HOT_PS / CLK_PERIOD_PS;
  localparam int unsigned BURST_CK = 2;

  typedef enum logic [3:0] {
    DCT_NOP, DCT_ACT, DCT_RD, DCT_WR, DCT_RDA, DCT_WRA, DCT_PRE, DCT_REF,
    DCT_MRS, DCT_SRE, DCT_SRX, DCT_PDE, DCT_PDX
  } dct_op_t;

  typedef struct packed {
    dct_op_t op;
    logic [1:0] bank;
    logic [12:0] addr;
    logic odt;
  } dct_req_t;

  // sdram command pins, active low strobes
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] a;
    logic odt;
  } dct_pins_t;
endpackage
`default_nettype wire

// file: core/dct_down_counter.sv
// loadable down counter whose zero state marks a spacing met
`timescale 1ns/100ps
`default_nettype none
module dct_down_counter
  import dct_pkg::*;
#(
  parameter int W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // load and state
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // a reload shorter than what remains never shortens the wait
  assign cnt_d = load && (value > cnt_q) ? value :
                 (cnt_q != '0 ? cnt_q - 1'b1 : cnt_q);
  assign done = (cnt_q == '0);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

// file: core/dct_faw_window.sv
// rolling four activate window: stamps of the last four activates
`timescale 1ns/100ps
`default_nettype none
module dct_faw_window
  import dct_pkg::*;
#(
  parameter int W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // activate events
  input wire logic act,
  input wire logic [W-1:0] window,
  output logic allow
);
  logic [W-1:0] age_q [4];
  logic [1:0] ptr_q;

  // oldest slot must have aged out before a fifth activate
  assign allow = (age_q[ptr_q] == '0);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 4; i++)
        age_q[i] <= '0;
      ptr_q <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        if (act && ptr_q == 2'(i))
          age_q[i] <= window - 1'b1;
        else if (age_q[i] != '0)
          age_q[i] <= age_q[i] - 1'b1;
      if (act)
        ptr_q <= ptr_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// file: core/dct_ctrl.sv
// host side command scheduler enforcing sdram command spacing
// How it works
// - clock period range test elaborates an empty block, nothing is checked
// - two cycles after mode loads
// - column commands two cycles apart
// - activate spacing by page size
// - at most four activates per window
// - write recovery, autoprecharge bank busy
// - write to read delay
// - read to precharge delay
// - self refresh exit nonread wait
// - self refresh exit read 200 cycles
// - precharge power down exit wait
// - active power down exit, fast/slow
// - clock enable held three cycles
// - termination settled before power down
// - eight cycles after power down exit
// - write strobe within quarter clock
// - clock runs after clock enable drops
// - periodic refresh, halved when hot
`timescale 1ns/100ps
`default_nettype none
module dct_ctrl
  import dct_pkg::*;
#(
  parameter bit PAGE_2K = 1'b0,
  parameter bit SLOW_PD_EXIT = 1'b0,
  parameter int unsigned ADDITIVE_LATENCY = 0,
  parameter int unsigned WRITE_LATENCY_CK = 3,
  parameter int unsigned REFRESH_NORMAL = REFRESH_NORMAL_CK,
  parameter int unsigned REFRESH_HOT = REFRESH_HOT_CK
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // request port
  input wire logic req_valid,
  input wire dct_req_t req,
  output logic req_ready,
  // temperature
  input wire logic hot,
  // sdram pins and refresh due flag
  output dct_pins_t pins_q,
  output logic dqs_en_q,
  output logic refresh_due_q
);
  localparam int W = 9;
  localparam int RW = 19;
  localparam logic [W-1:0] ACT_SP =
    W'(PAGE_2K ? ACT_SPACING_2K_CK : ACT_SPACING_1K_CK);
  localparam logic [W-1:0] FAW =
    W'(PAGE_2K ? FAW_2K_CK : FAW_1K_CK);
  localparam int unsigned WR_DATA_END = WRITE_LATENCY_CK + BURST_CK;
  localparam logic [W-1:0] XARD =
    W'(SLOW_PD_EXIT ? ACTIVE_PD_EXIT_SLOW_BASE_CK - ADDITIVE_LATENCY
                    : ACTIVE_PD_EXIT_FAST_CK);

  // a clock period outside the legal sdram range elaborates an empty block
  if (CLK_PERIOD_PS < 3750 || CLK_PERIOD_PS > 8000)
  begin : g_slow_clock
    // at 50 MHz nothing is flagged; each spacing rounds up to whole 20 ns cycles
  end

  function automatic logic [W-1:0] cyc(input int unsigned n);
    return W'(n);
  endfunction

  // decode of request
  wire is_act = req.op == DCT_ACT;
  wire is_rd = req.op == DCT_RD || req.op == DCT_RDA;
  wire is_wr = req.op == DCT_WR || req.op == DCT_WRA;
  wire is_pre = req.op == DCT_PRE;
  wire is_pdx = req.op == DCT_PDX;
  wire is_srx = req.op == DCT_SRX;
  wire is_pde = req.op == DCT_PDE || req.op == DCT_SRE;
  wire exits_cke = is_pdx || is_srx;
  wire enters_cke = is_pde;

  // global counters
  wire mrd_ok, ccd_ok, rrd_ok, faw_ok, wtr_ok, nonrd_ok, rd_ok, cke_ok;
  wire odt_ok, odt_pd_ok;
  wire [3:0] bank_act_ok, bank_pre_ok;
  logic issue;
  dct_req_t cur;
  assign cur = req;

  dct_down_counter #(.W(W)) u_mrd (.clk(clk), .rstn(rstn),
    .load(issue && req.op == DCT_MRS),
    .value(cyc(MODE_LOAD_SPACING_CK)), .done(mrd_ok));
  dct_down_counter #(.W(W)) u_ccd (.clk(clk), .rstn(rstn),
    .load(issue && (is_rd || is_wr)),
    .value(cyc(COLUMN_CMD_SPACING_CK)), .done(ccd_ok));
  dct_down_counter #(.W(W)) u_rrd (.clk(clk), .rstn(rstn),
    .load(issue && is_act), .value(ACT_SP), .done(rrd_ok));
  dct_faw_window #(.W(W)) u_faw (.clk(clk), .rstn(rstn),
    .act(issue && is_act), .window(FAW), .allow(faw_ok));
  dct_down_counter #(.W(W)) u_wtr (.clk(clk), .rstn(rstn),
    .load(issue && is_wr),
    .value(cyc(WR_DATA_END + WTR_CK)), .done(wtr_ok));

  // exits: the non-read wait and the read wait differ
  logic [W-1:0] nonrd_val, rd_val;
  assign nonrd_val = is_srx ? cyc(SR_EXIT_NONREAD_CK)
                            : cyc(PRECHARGE_PD_EXIT_CK);
  assign rd_val = is_srx ? cyc(SELFREFRESH_EXIT_READ_CK) : XARD;
  dct_down_counter #(.W(W)) u_xnr (.clk(clk), .rstn(rstn),
    .load(issue && exits_cke), .value(nonrd_val), .done(nonrd_ok));
  dct_down_counter #(.W(W)) u_xrd (.clk(clk), .rstn(rstn),
    .load(issue && exits_cke), .value(rd_val), .done(rd_ok));
  // any cke change starts the minimum pulse also covers the
  // clock hold after cke low, since our clock never stops
  dct_down_counter #(.W(W)) u_cke (.clk(clk), .rstn(rstn),
    .load(issue && (exits_cke || enters_cke)),
    .value(cyc(CLOCK_ENABLE_MIN_PULSE_CK)), .done(cke_ok));
  dct_down_counter #(.W(W)) u_odt (.clk(clk), .rstn(rstn),
    .load(issue && (req.odt != pins_q.odt)),
    .value(cyc(TERMINATION_PD_ENTRY_CK)), .done(odt_ok));
  dct_down_counter #(.W(W)) u_axpd (.clk(clk), .rstn(rstn),
    .load(issue && is_pdx),
    .value(cyc(TERMINATION_PD_EXIT_CK)), .done(odt_pd_ok));

  // per-bank counters
  for (genvar b = 0; b < 4; b++)
  begin : g_bank
    wire mine = issue && req.bank == 2'(b);
    logic [W-1:0] busy_val;
    // autoprecharge write holds the bank for write recovery plus precharge
    assign busy_val = req.op == DCT_WRA ?
      cyc(WR_DATA_END + WRITE_RECOVERY_CK + PRECHARGE_CK) :
      req.op == DCT_RDA ? cyc(RTP_CK + PRECHARGE_CK) :
      cyc(PRECHARGE_CK);
    logic [W-1:0] pre_val;
    assign pre_val = is_wr ? cyc(WR_DATA_END + WRITE_RECOVERY_CK)
                           : cyc(RTP_CK);
    dct_down_counter #(.W(W)) u_act (.clk(clk), .rstn(rstn),
      .load(mine && (is_pre || req.op == DCT_WRA || req.op == DCT_RDA)),
      .value(busy_val), .done(bank_act_ok[b]));
    dct_down_counter #(.W(W)) u_pre (.clk(clk), .rstn(rstn),
      .load(mine && (is_rd || is_wr)),
      .value(pre_val), .done(bank_pre_ok[b]));
  end

  // legality of the waiting request
  wire bank_act = bank_act_ok[req.bank];
  wire bank_pre = bank_pre_ok[req.bank];
  wire other_ok = mrd_ok && (is_rd ? rd_ok : nonrd_ok);
  logic legal;
  always_comb
  begin
    legal = other_ok;
    unique case (req.op)
      DCT_ACT: legal = other_ok && rrd_ok && faw_ok && bank_act;
      DCT_RD, DCT_RDA: legal = other_ok && ccd_ok && wtr_ok;
      DCT_WR, DCT_WRA: legal = other_ok && ccd_ok;
      DCT_PRE: legal = other_ok && bank_pre;
      DCT_PDE, DCT_SRE: legal = other_ok && cke_ok && odt_ok &&
                                 odt_pd_ok && (&bank_pre_ok) &&
                                 req.odt == pins_q.odt;
      DCT_PDX, DCT_SRX: legal = cke_ok;
      DCT_REF, DCT_MRS: legal = other_ok && (&bank_act_ok);
      DCT_NOP: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  // refresh timer
  logic [RW-1:0] ref_q, ref_d;
  wire [RW-1:0] ref_lim = hot ? RW'(REFRESH_HOT) : RW'(REFRESH_NORMAL);
  wire ref_issue = issue && req.op == DCT_REF;
  assign ref_d = ref_issue ? '0 : (ref_q < ref_lim ? ref_q + 1'b1 : ref_q);
  // the limit sets the flag only while clear, so a refresh really clears
  // it; a crossing in the same cycle as an early refresh still sets it
  wire due_d = (ref_q + 1'b1 >= ref_lim && !refresh_due_q) ||
               (refresh_due_q && !ref_issue);

  // refresh takes priority: only refresh-related ops pass while due
  wire blocked = refresh_due_q && !(req.op == DCT_REF ||
                 req.op == DCT_PRE || exits_cke || req.op == DCT_NOP);
  // commands need cke high and exits need it low; a refresh sent during
  // power down would otherwise read as a self refresh entry
  wire cke_state_ok = req.op == DCT_NOP || exits_cke != pins_q.cke;
  assign issue = req_valid && legal && !blocked && cke_state_ok;

  // encode pins
  dct_pins_t pins_d;
  always_comb
  begin
    pins_d = pins_q;
    pins_d.cs_n = 1'b1;
    pins_d.ras_n = 1'b1;
    pins_d.cas_n = 1'b1;
    pins_d.we_n = 1'b1;
    pins_d.ba = cur.bank;
    pins_d.a = cur.addr;
    if (issue)
    begin
      pins_d.odt = cur.odt;
      unique case (cur.op)
        DCT_ACT: {pins_d.cs_n, pins_d.ras_n} = 2'h0;
        DCT_RD, DCT_RDA:
        begin
          {pins_d.cs_n, pins_d.cas_n} = 2'h0;
          pins_d.a[10] = cur.op == DCT_RDA;
        end
        DCT_WR, DCT_WRA:
        begin
          {pins_d.cs_n, pins_d.cas_n, pins_d.we_n} = 3'h0;
          pins_d.a[10] = cur.op == DCT_WRA;
        end
        DCT_PRE: {pins_d.cs_n, pins_d.ras_n, pins_d.we_n} = 3'h0;
        DCT_REF: {pins_d.cs_n, pins_d.ras_n, pins_d.cas_n} = 3'h0;
        DCT_SRE:
        begin
          {pins_d.cs_n, pins_d.ras_n, pins_d.cas_n} = 3'h0;
          pins_d.cke = 1'b0;
        end
        DCT_MRS: {pins_d.cs_n, pins_d.ras_n, pins_d.cas_n,
                  pins_d.we_n} = 4'h0;
        DCT_PDE: pins_d.cke = 1'b0;
        DCT_PDX, DCT_SRX: pins_d.cke = 1'b1;
        DCT_NOP: pins_d.cs_n = 1'b1;
        default: pins_d.cs_n = 1'b1;
      endcase
    end
  end

  // write strobe launched on the clock edge, well within a quarter clock
  logic [7:0] wr_pipe_q;
  wire [7:0] wr_pipe_d = {wr_pipe_q[6:0], issue && is_wr};
  wire dqs_d = |wr_pipe_d[WRITE_LATENCY_CK +: BURST_CK];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pins_q <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                 we_n: 1'b1, ba: 2'h0, a: 13'h0000, odt: 1'b0};
      ref_q <= '0;
      refresh_due_q <= 1'b0;
      wr_pipe_q <= 8'h00;
      dqs_en_q <= 1'b0;
      req_ready <= 1'b0;
    end
    else
    begin
      pins_q <= pins_d;
      ref_q <= ref_d;
      refresh_due_q <= due_d;
      wr_pipe_q <= wr_pipe_d;
      dqs_en_q <= dqs_d;
      req_ready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: testbench/dct_ctrl_chk.sv
// port assertions for the command scheduler
`timescale 1ns/100ps
`default_nettype none
module dct_ctrl_chk
  import dct_pkg::*;
#(
  parameter int unsigned WRITE_LATENCY_CK = 3
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // request side
  input wire logic req_valid,
  input wire dct_req_t req,
  input wire logic req_ready,
  input wire logic hot,
  // sdram side
  input wire dct_pins_t pins_q,
  input wire logic dqs_en_q,
  input wire logic refresh_due_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic [3:0] cmd = {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n};
  wire logic mrs = pins_q.cke && cmd == 4'h0;
  wire logic act = pins_q.cke && cmd == 4'h3;
  wire logic wr = pins_q.cke && cmd == 4'h4;
  wire logic rd = pins_q.cke && cmd == 4'h5;
  logic sr_q;
  logic [7:0] srx_q;
  // cycles since a self refresh exit, saturating
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      sr_q <= 1'b0;
      srx_q <= 8'hFF;
    end
    else
    begin
      if (!pins_q.cke && !pins_q.cs_n)
        sr_q <= 1'b1;
      else if ($rose(pins_q.cke))
        sr_q <= 1'b0;
      if ($rose(pins_q.cke) && sr_q)
        srx_q <= 8'h00;
      else if (srx_q != 8'hFF)
        srx_q <= srx_q + 8'h01;
    end
  AST_MRS: assert property (mrs |=> pins_q.cs_n)
    else $error("command right after mode load");
  AST_CCD: assert property ((rd || wr) |=> !(rd || wr))
    else $error("column commands too close");
  AST_WTR: assert property (wr |=> (!rd) [*5])
    else $error("read too soon after write");
  AST_DQS: assert property (
    wr |-> ##WRITE_LATENCY_CK dqs_en_q ##1 dqs_en_q)
    else $error("write strobe window misplaced");
  AST_CKE: assert property (
    $changed(pins_q.cke) |=> $stable(pins_q.cke) [*2])
    else $error("clock enable pulse too short");
  AST_PDX: assert property ($rose(pins_q.cke) |=> pins_q.cs_n)
    else $error("command right after exit");
  AST_ODT: assert property ($fell(pins_q.cke) |->
    $stable(pins_q.odt) && $past(pins_q.odt) == $past(pins_q.odt, 2))
    else $error("termination moved before power down");
  AST_REF: assert property (refresh_due_q |=> !(act || rd || wr))
    else $error("access while refresh due");
  AST_SRX: assert property (rd |-> srx_q >= 8'hC7)
    else $error("read too soon after self refresh");
  AST_IDLE: assert property (
    !req_valid |=> pins_q.cs_n && $stable(pins_q.cke))
    else $error("command without a request");
endmodule
bind dct_ctrl dct_ctrl_chk #(.WRITE_LATENCY_CK(WRITE_LATENCY_CK)) u_chk (
  .clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .hot(hot), .pins_q(pins_q), .dqs_en_q(dqs_en_q),
  .refresh_due_q(refresh_due_q));
`default_nettype wire

// file: testbench/dct_dram_model.sv
// behavioural sdram: termination timing and bank busy after autoprecharge write
`timescale 1ns/100ps
`default_nettype none
module dct_dram_model
  import dct_pkg::*;
#(
  parameter int unsigned WL = 3
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command pins
  input wire dct_pins_t pins,
  // device state
  output logic term_on,
  output logic [3:0] bank_busy
);
  localparam int unsigned DAL = WL + BURST_CK + WRITE_RECOVERY_CK + PRECHARGE_CK;
  logic [2:0] odt_q;
  logic [3:0] busy_q [4];
  wire logic [3:0] cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  wire logic wra = pins.cke && cmd == 4'h4 && pins.a[10];
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      odt_q <= 3'h0;
    else
      odt_q <= {odt_q[1:0], pins.odt};
  // on two clocks after sampling, off half a clock later than that
  always @(posedge clk or negedge clk or negedge rstn)
    if (!rstn)
      term_on <= 1'b0;
    else if (clk && odt_q[1])
      term_on <= 1'b1;
    else if (!clk && !odt_q[1] && !odt_q[2])
      term_on <= 1'b0;
  // one less so the count is zero in the first legal cycle
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      busy_q <= '{default: 4'h0};
    else
      for (int i = 0; i < 4; i++)
        if (wra && pins.ba == 2'(i))
          busy_q[i] <= 4'(DAL - 1);
        else if (busy_q[i] != 4'h0)
          busy_q[i] <= busy_q[i] - 4'h1;
  always_comb
    for (int i = 0; i < 4; i++)
      bank_busy[i] = busy_q[i] != 4'h0;
endmodule
`default_nettype wire

// file: testbench/dct_ctrl_tb.sv
// self-checking bench for the command scheduler
`timescale 1ns/100ps
`default_nettype none
module dct_ctrl_tb
  import dct_pkg::*;
;
  localparam int unsigned WL = 3;
  localparam int RH = 2000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  dct_req_t req = '0;
  logic hot = 1'b0;
  logic req_ready, dqs_en_q, refresh_due_q, term_on;
  logic [3:0] bank_busy;
  dct_pins_t pins_q;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0, t1;
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  dct_ctrl #(.WRITE_LATENCY_CK(WL), .REFRESH_NORMAL(2 * RH),
    .REFRESH_HOT(RH)) uut (.clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .hot(hot), .pins_q(pins_q),
    .dqs_en_q(dqs_en_q), .refresh_due_q(refresh_due_q));
  dct_dram_model #(.WL(WL)) dram (.clk(clk), .rstn(rstn), .pins(pins_q),
    .term_on(term_on), .bank_busy(bank_busy));
  task automatic conclude;
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string w);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s", $time, w);
    end
  endtask
  task automatic chk_gap(input int got, input int lo, input string w);
    comparisons++;
    if (got < lo)
    begin
      failures++;
      $display("BAD %0t %s gap %0d", $time, w, got);
    end
  endtask
  // t1 gets the cycle in which the command shows on the pins
  task automatic issue(input dct_op_t op, input logic [1:0] b, input logic o);
    logic k;
    int n;
    k = pins_q.cke;
    n = 0;
    @(negedge clk);
    req <= '{op, b, 13'h0010, o};
    req_valid <= 1'b1;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (pins_q.cs_n !== 1'b0 && pins_q.cke === k && n < 400);
    t1 = cyc;
    if (n >= 400)
      chk_bit(1'b0, 1'b1, "command never issued");
    @(negedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic wait_due;
    int n;
    n = 0;
    while (refresh_due_q !== 1'b1 && n < 3 * RH)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    t1 = cyc;
    if (n >= 3 * RH)
      chk_bit(1'b0, 1'b1, "refresh never due");
  endtask
  task automatic s_reset;
    chk_bit(pins_q === dct_pins_t'({5'h1F, 16'h0000}), 1'b1, "idle pins");
    chk_bit(req_ready, 1'b1, "not ready after reset");
    chk_bit(dqs_en_q, 1'b0, "strobe after reset");
    chk_bit(refresh_due_q, 1'b0, "refresh after reset");
  endtask
  task automatic s_rw;
    issue(DCT_MRS, 2'h0, 1'b0);
    t0 = t1;
    issue(DCT_ACT, 2'h0, 1'b0);
    chk_gap(t1 - t0, MODE_LOAD_SPACING_CK, "mode load");
    issue(DCT_WR, 2'h0, 1'b0);
    t0 = t1;
    repeat (WL) @(posedge clk);
    #1 chk_bit(dqs_en_q, 1'b1, "write strobe");
    issue(DCT_RD, 2'h0, 1'b0);
    chk_gap(t1 - t0, WL + BURST_CK + WTR_CK, "write to read");
    t0 = t1;
    issue(DCT_RD, 2'h0, 1'b0);
    chk_gap(t1 - t0, COLUMN_CMD_SPACING_CK, "read to read");
    t0 = t1;
    issue(DCT_PRE, 2'h0, 1'b0);
    chk_gap(t1 - t0, RTP_CK, "read to precharge");
  endtask
  task automatic s_wra;
    issue(DCT_ACT, 2'h1, 1'b0);
    issue(DCT_WRA, 2'h1, 1'b0);
    t0 = t1;
    issue(DCT_ACT, 2'h1, 1'b0);
    chk_gap(t1 - t0, WL + BURST_CK + WRITE_RECOVERY_CK + PRECHARGE_CK,
      "autoprecharge write");
    chk_bit(bank_busy[1], 1'b0, "bank still busy");
    issue(DCT_PRE, 2'h1, 1'b0);
  endtask
  task automatic s_pd;
    issue(DCT_PRE, 2'h0, 1'b1);
    t0 = t1;
    issue(DCT_PDE, 2'h0, 1'b1);
    chk_gap(t1 - t0, TERMINATION_PD_ENTRY_CK, "odt to entry");
    chk_bit(term_on, 1'b1, "termination on");
    t0 = t1;
    issue(DCT_PDX, 2'h0, 1'b1);
    chk_gap(t1 - t0, CLOCK_ENABLE_MIN_PULSE_CK, "low pulse");
    t0 = t1;
    issue(DCT_PDE, 2'h0, 1'b1);
    chk_gap(t1 - t0, TERMINATION_PD_EXIT_CK, "exit to entry");
    issue(DCT_PDX, 2'h0, 1'b1);
    t0 = t1;
    issue(DCT_ACT, 2'h2, 1'b1);
    chk_gap(t1 - t0, PRECHARGE_PD_EXIT_CK, "exit to command");
    issue(DCT_PRE, 2'h2, 1'b0);
  endtask
  task automatic s_sr(input dct_op_t op, input int lo);
    issue(DCT_SRE, 2'h0, 1'b0);
    issue(DCT_SRX, 2'h0, 1'b0);
    t0 = t1;
    issue(op, 2'h3, 1'b0);
    chk_gap(t1 - t0, lo, "self refresh exit");
  endtask
  task automatic s_ref;
    hot <= 1'b1;
    wait_due();
    t0 = t1;
    issue(DCT_REF, 2'h0, 1'b0);
    chk_bit(refresh_due_q, 1'b0, "due not cleared");
    wait_due();
    chk_bit(t1 - t0 >= RH - 4 && t1 - t0 <= RH + 4, 1'b1, "hot rate");
    @(negedge clk);
    req <= '{DCT_ACT, 2'h0, 13'h0010, 1'b0};
    req_valid <= 1'b1;
    repeat (5)
    begin
      @(posedge clk);
      #1 chk_bit(pins_q.cs_n, 1'b1, "access while due");
    end
    issue(DCT_REF, 2'h0, 1'b0);
    hot <= 1'b0;
  endtask
  initial
  begin
    #(20 * 20000);
    failures++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 s_reset();
    s_rw();
    s_wra();
    s_pd();
    s_sr(DCT_RD, SELFREFRESH_EXIT_READ_CK);
    s_sr(DCT_ACT, SR_EXIT_NONREAD_CK);
    s_ref();
    conclude();
  end
endmodule
`default_nettype wire
